// >>> common/spbch_pkg.sv
package spbch_pkg;
  localparam logic [7:0]  CMD_MGMT     = 8'hf4;
  localparam logic [7:0]  CMD_LOAD     = 8'hf6;
  localparam logic [7:0]  CMD_TEMP_REQ = 8'ha5;
  localparam logic [7:0]  CMD_TEMP_RSP = 8'ha6;
  localparam logic [7:0]  CMD_FAN_CTL  = 8'ha8;
  localparam logic [7:0]  CMD_FAN_REQ  = 8'ha9;
  localparam logic [7:0]  CMD_FAN_RSP  = 8'haa;
  localparam logic [15:0] LEN_MODE     = 16'h0004;
  localparam logic [15:0] LEN_PORT     = 16'h0005;
  localparam logic [15:0] LEN_QRY      = 16'h0003;
  localparam logic [7:0]  LEN_TEMP     = 8'h06;
  localparam logic [7:0]  LEN_FAN      = 8'h03;
  localparam logic [15:0] LEN_NAK      = 16'h0002;
  localparam logic [15:0] LEN_STAT     = 16'h0051;
  localparam logic [15:0] LOAD_MAX     = 16'h0401;
  localparam logic [23:0] SUB2_MODE    = 24'h50_4d53;
  localparam logic [23:0] SUB2_SET     = 24'h53_4543;
  localparam logic [23:0] SUB2_QRY     = 24'h45_4352;
  localparam logic [23:0] SUB2_RPT     = 24'h52_4543;
  localparam logic [7:0]  SUB_REQ      = 8'hd1;
  localparam logic [7:0]  SUB_START    = 8'hd2;
  localparam logic [7:0]  SUB_CHUNK    = 8'hd3;
  localparam logic [7:0]  SUB_DONE     = 8'hd4;
  localparam logic [7:0]  SUB_STATQ    = 8'hd8;
  localparam logic [7:0]  SUB_NAK      = 8'hd5;
  localparam logic [7:0]  SUB_STAT     = 8'hdc;
  localparam logic [7:0]  ERR_NONE     = 8'h00;
  localparam logic [7:0]  ERR_CKSUM    = 8'h01;
  localparam logic [7:0]  ERR_SEQ      = 8'h02;
  localparam logic [1:0]  MODE_ALL     = 2'h1;
  localparam logic [1:0]  MODE_UNUSED  = 2'h2;
  localparam logic [1:0]  MODE_NONE    = 2'h3;
  localparam logic [6:0]  RL_TEMP      = 7'h07;
  localparam logic [6:0]  RL_FAN       = 7'h04;
  localparam logic [6:0]  RL_RPT       = 7'h06;
  localparam logic [6:0]  RL_NAK       = 7'h04;
  localparam logic [6:0]  RL_STAT      = 7'h53;
  localparam logic [6:0]  STAT_HDR     = 7'h04;
  localparam logic [6:0]  INFO_DEPTH   = 7'h50;
  localparam logic [3:0]  REG_THERM    = 4'h0;
  localparam logic [3:0]  REG_CFG      = 4'h4;
  localparam logic [3:0]  REG_STAT     = 4'h8;
  localparam logic [3:0]  REG_INFO     = 4'hc;
  localparam logic [31:0] THERM_RST    = 32'h0000_0000;
  localparam logic [10:0] CFG_RST      = 11'h000;
  localparam int          CFG_FLT_LSB  = 8;
  localparam int          INFO_IDX_LSB = 8;
  localparam int          ST_MODE_LSB  = 0;
  localparam int          ST_FAN_BIT   = 2;
  localparam int          ST_P1_BIT    = 3;
  localparam int          ST_P2_BIT    = 4;
  localparam int          ST_PH_LSB    = 5;
  localparam logic [1:0]  RESP_OK      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam int          CLK_HZ       = 25_000_000;
  localparam int          CLK_NS       = 40;
  localparam int          RESP_TIME_S  = 1;
  localparam int          RESP_CYC     = CLK_HZ * RESP_TIME_S;
  localparam int          FAN_TICK_NS  = 2560;
  localparam logic [6:0]  FAN_TICK_CYC = 7'(FAN_TICK_NS / CLK_NS);
  localparam logic [15:0] FAN_NONE     = 16'hffff;
  typedef enum logic [2:0] {
    S_CMD, S_LENH, S_LENL, S_DATA, S_EXEC, S_FETCH, S_LOAD, S_SEND
  } spbch_st_t;
  typedef enum logic [2:0] {
    K_TEMP, K_FAN, K_RPT, K_NAK, K_STAT
  } spbch_rsp_t;
  typedef enum logic [1:0] {P_IDLE, P_REQ, P_RUN, P_DONE} spbch_dl_t;
endpackage

// >>> logic/spbch_info_mem.sv
`timescale 1ns/100ps
module spbch_info_mem
  import spbch_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       we,
  input  wire logic [6:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [6:0] raddr,
  output logic      [7:0] rdata
);
  // hash characters then part number
  logic [7:0] mem [INFO_DEPTH];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// >>> logic/spbch_fan_meter.sv
`timescale 1ns/100ps
module spbch_fan_meter
  import spbch_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        fan_tach,
  output logic      [15:0] period
);
  typedef struct packed {
    logic [5:0]  div;
    logic [15:0] cnt;
    logic        tach_d;
    logic [15:0] period;
  } spbch_fan_t;

  spbch_fan_t s, n;
  logic       tick;

  assign tick = s.div == 6'(FAN_TICK_CYC - 7'h01);
  assign period = s.period;

  // period counted in 2.56 us ticks, saturating at no-rotation
  always_comb begin
    n = s;
    n.tach_d = fan_tach;
    n.div = tick ? 6'h00 : s.div + 6'h01;
    if (fan_tach && !s.tach_d) begin
      n.period = s.cnt;
      n.cnt = 16'h0000;
    end else if (tick && s.cnt != FAN_NONE) begin
      n.cnt = s.cnt + 16'h0001;
    end
    if (s.cnt == FAN_NONE) begin
      n.period = FAN_NONE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '{div: 6'h00, cnt: 16'h0000, tach_d: 1'b0, period: FAN_NONE};
    end else begin
      s <= n;
    end
  end
endmodule

// >>> logic/spbch_top.sv
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module spbch_top
  import spbch_pkg::*;
#(
  parameter int unsigned RESP_LIMIT_CYC = RESP_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  input  wire logic        rx_last,
  input  wire logic        rx_bad,
  output logic             rx_ready,
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  output logic             tx_last,
  input  wire logic        tx_ready,
  output logic      [7:0]  img_data,
  output logic             img_valid,
  input  wire logic        img_ready,
  input  wire logic [7:0]  temp_in,
  input  wire logic        fan_tach,
  output logic      [1:0]  outlet_mode,
  output logic             fan_on,
  output logic             port_up_en,
  output logic             port_dn1_en,
  output logic             port_dn2_en
);
  typedef struct packed {
    spbch_st_t  st;
    logic [7:0]  cmd;
    logic [15:0] len;
    logic [15:0] cnt;
    logic [7:0]  sub;
    logic [23:0] cmd2;
    logic [7:0]  b3;
    logic [7:0]  b4;
    logic        fwd;
    logic        bad;
    logic        img_v;
    logic [7:0]  img_d;
    spbch_rsp_t  rk;
    logic [6:0]  ridx;
    logic [6:0]  rlast;
    logic [7:0]  tx_d;
    logic        tx_l;
    logic [7:0]  code;
    logic [1:0]  mode;
    logic        fan;
    logic        p1;
    logic        p2;
    spbch_dl_t   ph;
    logic        fin;
    logic [31:0] therm;
    logic [10:0] cfg;
    logic        aw_got;
    logic [3:0]  aw_a;
    logic        w_got;
    logic [31:0] w_d;
    logic [3:0]  w_s;
    logic        bv;
    logic [1:0]  br;
    logic        rv;
    logic [31:0] rd;
    logic [1:0]  rr;
    logic [31:0] wait_cnt;
  } spbch_state_t;

  spbch_state_t s, n;
  logic        rx_fire;
  logic        opc;
  logic        mem_we;
  logic [6:0]  mem_raddr;
  logic [7:0]  mem_rdata;
  logic [15:0] fan_period;
  logic [63:0] hv;
  logic [63:0] shv;
  logic [7:0]  rbyte;
  logic        rsp_go;
  spbch_rsp_t  rsp_k;
  logic        len_ok;
  logic [31:0] stat_word;
  logic [7:0]  flt;

  spbch_info_mem u_mem (
    .aclk  (aclk),
    .we    (mem_we),
    .waddr (s.w_d[INFO_IDX_LSB +: 7]),
    .wdata (s.w_d[7:0]),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  spbch_fan_meter u_fan (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .fan_tach (fan_tach),
    .period   (fan_period)
  );

  assign opc = s.st == S_DATA && s.fwd && s.cnt != 16'h0000;
  assign rx_ready = (s.st == S_CMD || s.st == S_LENH || s.st == S_LENL ||
                     s.st == S_DATA) && (!opc || !s.img_v || img_ready);
  assign rx_fire = rx_valid && rx_ready;
  assign awready = !s.aw_got && !s.bv;
  assign wready = !s.w_got && !s.bv;
  assign arready = !s.rv;
  assign bvalid = s.bv;
  assign bresp = s.br;
  assign rvalid = s.rv;
  assign rdata = s.rd;
  assign rresp = s.rr;
  assign tx_valid = s.st == S_SEND;
  assign tx_data = s.tx_d;
  assign tx_last = s.tx_l;
  assign img_valid = s.img_v;
  assign img_data = s.img_d;
  assign outlet_mode = s.mode;
  assign fan_on = s.fan;
  assign port_up_en = 1'b1;
  assign port_dn1_en = s.p1;
  assign port_dn2_en = s.p2;
  assign mem_we = s.aw_got && s.w_got && s.aw_a == REG_INFO &&
                  s.w_s[0] && s.w_s[1] &&
                  s.w_d[INFO_IDX_LSB +: 7] < INFO_DEPTH;
  assign mem_raddr = s.ridx - STAT_HDR;
  assign len_ok = s.len != 16'h0000 && s.len <= LOAD_MAX;
  assign flt = {5'h00, s.cfg[CFG_FLT_LSB +: 3]};

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[ST_MODE_LSB +: 2] = s.mode;
    stat_word[ST_FAN_BIT] = s.fan;
    stat_word[ST_P1_BIT] = s.p1;
    stat_word[ST_P2_BIT] = s.p2;
    stat_word[ST_PH_LSB +: 2] = s.ph;
  end

  // response bytes, the first eight packed high to low; status reply bytes from STAT_HDR on come from the info memory
  always_comb begin
    case (s.rk)
      K_TEMP: hv = {CMD_TEMP_RSP, LEN_TEMP, s.therm[7:0], s.therm[15:8],
                    s.therm[23:16], s.therm[31:24], s.cfg[7:0],
                    temp_in};
      K_FAN: hv = {CMD_FAN_RSP, LEN_FAN, 7'h00, s.fan, fan_period,
                   24'h00_0000};
      K_RPT: hv = {CMD_MGMT, LEN_PORT[7:0], SUB2_RPT, 7'h00, s.p1,
                   7'h00, s.p2, 8'h00};
      K_NAK: hv = {CMD_LOAD, LEN_NAK, SUB_NAK, s.code,
                   24'h00_0000};
      K_STAT: hv = {CMD_LOAD, LEN_STAT, SUB_STAT,
                    32'h0000_0000};
      default: hv = 64'h0000_0000_0000_0000;
    endcase
    shv = hv << {s.ridx[2:0], 3'b000};
    if (s.rk == K_STAT && s.ridx >= STAT_HDR) begin
      rbyte = mem_rdata;
    end else begin
      rbyte = shv[63:56];
    end
  end

  always_comb begin
    n = s;
    rsp_go = 1'b0;
    rsp_k = K_NAK;
    if (s.img_v && img_ready) begin
      n.img_v = 1'b0;
    end
    case (s.st)
      S_CMD: if (rx_fire) begin
        n.cmd = rx_data;
        n.len = 16'h0000;
        n.cnt = 16'h0000;
        n.cmd2 = 24'h00_0000;
        n.fwd = 1'b0;
        n.st = rx_data == CMD_LOAD ? S_LENH : S_LENL;
      end
      S_LENH: if (rx_fire) begin
        n.len[15:8] = rx_data;
        n.st = S_LENL;
      end
      S_LENL: if (rx_fire) begin
        n.len[7:0] = rx_data;
        n.st = S_DATA;
      end
      S_DATA: if (rx_fire) begin
        if (s.cnt == 16'h0000) begin
          n.sub = rx_data;
          n.fwd = s.cmd == CMD_LOAD && rx_data == SUB_CHUNK &&
                  s.ph == P_RUN && !s.fin;
        end
        if (s.cnt < 16'h0003) begin
          n.cmd2 = {s.cmd2[15:0], rx_data};
        end
        if (s.cnt == 16'h0003) begin
          n.b3 = rx_data;
        end
        if (s.cnt == 16'h0004) begin
          n.b4 = rx_data;
        end
        if (opc) begin
          n.img_v = 1'b1;
          n.img_d = rx_data;
        end
        n.cnt = s.cnt + 16'h0001;
      end
      S_EXEC: begin
        n.st = S_CMD;
        case (s.cmd)
          CMD_MGMT: begin
            if (s.len == LEN_MODE && s.cmd2 == SUB2_MODE) begin
              if (s.b3 >= 8'h01 && s.b3 <= 8'h03) begin
                n.mode = s.b3[1:0];
              end
            end else if (s.len == LEN_PORT && s.cmd2 == SUB2_SET) begin
              n.p1 = s.b3[0];
              n.p2 = s.b4[0];
            end else if (s.len == LEN_QRY && s.cmd2 == SUB2_QRY) begin
              rsp_go = 1'b1;
              rsp_k = K_RPT;
            end
          end
          CMD_TEMP_REQ: begin
            rsp_go = 1'b1;
            rsp_k = K_TEMP;
          end
          CMD_FAN_CTL: n.fan = !s.fan;
          CMD_FAN_REQ: begin
            rsp_go = 1'b1;
            rsp_k = K_FAN;
          end
          CMD_LOAD: begin
            rsp_go = 1'b1;
            n.code = ERR_SEQ;
            if (s.bad) begin
              n.code = ERR_CKSUM;
            end else if (len_ok) begin
              case (s.sub)
                SUB_REQ: begin
                  n.ph = P_REQ;
                  n.fin = 1'b0;
                  n.code = ERR_NONE;
                end
                SUB_START: if (s.ph == P_REQ) begin
                  n.ph = P_RUN;
                  n.code = ERR_NONE;
                end
                SUB_CHUNK: if (s.ph == P_RUN && !s.fin) begin
                  n.fin = s.len != LOAD_MAX;
                  n.code = ERR_NONE;
                end
                SUB_DONE: if (s.ph == P_RUN) begin
                  n.code = flt;
                  if (flt == ERR_NONE) begin
                    n.ph = P_DONE;
                  end
                end
                SUB_STATQ: begin
                  rsp_k = K_STAT;
                  n.code = ERR_NONE;
                end
                default: n.code = ERR_SEQ;
              endcase
            end
          end
          default: n.st = S_CMD;
        endcase
        if (rsp_go) begin
          n.st = S_FETCH;
          n.rk = rsp_k;
          n.ridx = 7'h00;
          case (rsp_k)
            K_TEMP: n.rlast = RL_TEMP;
            K_FAN: n.rlast = RL_FAN;
            K_RPT: n.rlast = RL_RPT;
            K_STAT: n.rlast = RL_STAT;
            default: n.rlast = RL_NAK;
          endcase
        end
      end
      S_FETCH: n.st = S_LOAD;
      S_LOAD: begin
        n.tx_d = rbyte;
        n.tx_l = s.ridx == s.rlast;
        n.st = S_SEND;
      end
      S_SEND: if (tx_ready) begin
        n.ridx = s.ridx + 7'h01;
        n.st = s.tx_l ? S_CMD : S_FETCH;
      end
      default: n.st = S_CMD;
    endcase
    if (rx_fire && rx_last) begin
      n.st = S_EXEC;
      n.bad = rx_bad;
    end
    if (s.st == S_EXEC || s.st == S_FETCH || s.st == S_LOAD ||
        s.st == S_SEND) begin
      n.wait_cnt = s.wait_cnt + 32'h0000_0001;
    end else begin
      n.wait_cnt = 32'h0000_0000;
    end
    // register slave: write needs both channels, then one response
    if (awvalid && awready) begin
      n.aw_got = 1'b1;
      n.aw_a = awaddr;
    end
    if (wvalid && wready) begin
      n.w_got = 1'b1;
      n.w_d = wdata;
      n.w_s = wstrb;
    end
    if (s.bv && bready) begin
      n.bv = 1'b0;
    end
    if (s.aw_got && s.w_got) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bv = 1'b1;
      n.br = RESP_OK;
      case (s.aw_a)
        REG_THERM: for (int i = 0; i < 4; i++) begin
          if (s.w_s[i]) begin
            n.therm[8*i +: 8] = s.w_d[8*i +: 8];
          end
        end
        REG_CFG: begin
          if (s.w_s[0]) begin
            n.cfg[7:0] = s.w_d[7:0];
          end
          if (s.w_s[1]) begin
            n.cfg[10:8] = s.w_d[10:8];
          end
        end
        REG_INFO: n.br = RESP_OK;
        default: n.br = RESP_SLVERR;
      endcase
    end
    if (s.rv && rready) begin
      n.rv = 1'b0;
    end
    if (arvalid && arready) begin
      n.rv = 1'b1;
      n.rr = RESP_OK;
      case (araddr)
        REG_THERM: n.rd = s.therm;
        REG_CFG: n.rd = {21'h00_0000, s.cfg};
        REG_STAT: n.rd = stat_word;
        default: begin
          n.rd = 32'h0000_0000;
          n.rr = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.st <= S_CMD;
      s.rk <= K_NAK;
      s.ph <= P_IDLE;
      s.mode <= MODE_ALL;
      s.therm <= THERM_RST;
      s.cfg <= CFG_RST;
    end else begin
      s <= n;
    end
  end

  a_mode_apply: assert property (@(posedge aclk) disable iff (!aresetn)
    s.st == S_EXEC && s.cmd == CMD_MGMT && s.len == LEN_MODE &&
    s.cmd2 == SUB2_MODE && s.b3 == 8'h03 |=> outlet_mode == MODE_NONE)
    else $error("power mode 3 not applied");
  a_mode_skip: assert property (@(posedge aclk) disable iff (!aresetn)
    s.st == S_EXEC && s.cmd == CMD_MGMT && s.cmd2 == SUB2_MODE &&
    (s.b3 == 8'h00 || s.b3 > 8'h03) |=> $stable(outlet_mode))
    else $error("bad power mode changed outlets");
  a_fan_flip: assert property (@(posedge aclk) disable iff (!aresetn)
    s.st == S_EXEC && s.cmd == CMD_FAN_CTL |=> fan_on != $past(fan_on))
    else $error("fan did not toggle");
  a_temp_head: assert property (@(posedge aclk) disable iff (!aresetn)
    s.st == S_EXEC && s.cmd == CMD_TEMP_REQ |->
    ##3 tx_valid && tx_data == CMD_TEMP_RSP)
    else $error("temperature reply missing");
  a_port_set: assert property (@(posedge aclk) disable iff (!aresetn)
    s.st == S_EXEC && s.cmd == CMD_MGMT && s.len == LEN_PORT &&
    s.cmd2 == SUB2_SET |=> port_dn2_en == $past(s.b4[0]))
    else $error("port setting not applied");
  a_nak_code: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_valid && tx_ready && s.rk == K_NAK && s.ridx == 7'h03 |->
    tx_data == SUB_NAK ##1 !tx_valid [*2] ##1 tx_valid && tx_last)
    else $error("download answer malformed");
  a_stat_len: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_valid && s.rk == K_STAT && s.ridx == 7'h02 |->
    tx_data == LEN_STAT[7:0])
    else $error("status length wrong");
  a_resp_due: assert property (@(posedge aclk) disable iff (!aresetn)
    s.wait_cnt < RESP_LIMIT_CYC)
    else $error("reply later than one second");
endmodule

// >>> dv/spbch_mgmt_node.sv
`timescale 1ns/100ps
module spbch_mgmt_node (
  input  wire logic       aclk,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  output logic            rx_last,
  output logic            rx_bad,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  output logic            tx_ready,
  input  wire logic [7:0] img_data,
  input  wire logic       img_valid,
  output logic            img_ready
);
  logic [7:0] rsp_q[$];
  logic [7:0] img_q[$];
  int         done;
  int         stuck;

  initial begin
    {rx_data, rx_valid, rx_last, rx_bad} = '0;
    {tx_ready, img_ready} = 2'b11;
  end

  // reply and image sinks stall at random
  always @(posedge aclk) begin
    if (tx_valid && tx_ready) begin
      rsp_q.push_back(tx_data);
      done += int'(tx_last);
    end
    if (img_valid && img_ready)
      img_q.push_back(img_data);
    tx_ready  <= ($urandom % 3) != 0;
    img_ready <= ($urandom % 3) != 0;
  end

  // one whole message, byte by byte, each held until taken or for at most 3000 cycles
  task automatic send(int m[$], bit bad);
    int k;
    foreach (m[i]) begin
      rx_data  <= 8'(m[i]);
      rx_valid <= 1'b1;
      rx_last  <= i == m.size() - 1;
      rx_bad   <= bad && i == m.size() - 1;
      k = 0;
      do begin
        @(posedge aclk);
        k++;
      end while (!rx_ready && k < 3000);
      stuck += int'(k >= 3000);
    end
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    rx_bad   <= 1'b0;
    rx_data  <= ~rx_data;
  endtask
endmodule

// >>> dv/spbch_top_tb.sv
`timescale 1ns/100ps
module spbch_top_tb
  import spbch_pkg::*;
;
  localparam int LIM = 2000;
  logic        aclk = 1'b0;
  logic        aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rx_valid, rx_last, rx_bad;
  logic        rx_ready, tx_valid, tx_last, tx_ready, img_valid, img_ready;
  logic        fan_tach, fan_on, port_up_en, port_dn1_en, port_dn2_en;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd, th;
  logic [1:0]  bresp, rresp, rs, outlet_mode;
  logic [7:0]  rx_data, tx_data, img_data, temp_in, ivl;
  logic [7:0]  tv[3];
  logic [7:0]  b[3];
  int          error_cnt, tests_run, exp_mode, exp_fan;
  int          modes[5] = '{2, 3, 4, 1, 0};

  always #20 aclk = ~aclk;

  spbch_top #(.RESP_LIMIT_CYC(LIM)) dut_u (.*);
  spbch_mgmt_node node_u (.*);

  task automatic print_verdict;
    error_cnt += node_u.stuck;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(string w, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", w, e, g);
    end
  endtask

  task automatic tmo(int k);
    if (k >= 3000) begin
      chk("wait_bound", 0, 1);
      print_verdict;
    end
  endtask

  // one message; a stuck byte ends the run
  task automatic msg(int m[$], bit bad);
    node_u.send(m, bad);
    if (node_u.stuck != 0) tmo(3000);
  endtask

  task automatic chk_rsp(int e[$], int len);
    int k;
    int lat;
    lat = 0;
    for (k = 0; k < 3000 && node_u.done == 0; k++) begin
      @(posedge aclk);
      lat += int'(node_u.rsp_q.size() == 0);
    end
    tmo(k);
    chk("rsp_time", 1, lat < LIM);
    chk("rsp_len", len, node_u.rsp_q.size());
    foreach (e[i]) chk("rsp_byte", e[i], node_u.rsp_q[i]);
    node_u.rsp_q = {};
    node_u.done = 0;
  endtask

  task automatic axi_wr(logic [3:0] a, logic [31:0] d);
    int k;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (k = 0; k < 3000; k++) begin
      @(posedge aclk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
      if (bvalid) break;
    end
    tmo(k);
    rs = bresp;
  endtask

  task automatic axi_rd(logic [3:0] a);
    int k;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (k = 0; k < 3000; k++) begin
      @(posedge aclk);
      if (arready && arvalid) arvalid <= 1'b0;
      if (rvalid) break;
    end
    tmo(k);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // load message, answer is ack (code 00) or negative ack
  task automatic ld(int d[$], int code, bit bad);
    msg({CMD_LOAD, d.size() >> 8, d.size() & 255, d}, bad);
    chk_rsp('{CMD_LOAD, 0, 2, SUB_NAK, code}, 5);
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, fan_tach} = '0;
    {awaddr, araddr, wdata, temp_in} = '0;
    wstrb = 4'hf;
    th = $urandom(32'h5f63);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("ports", 3'b100, {port_up_en, port_dn1_en, port_dn2_en});
    chk("fan_on", 0, fan_on);
    exp_mode = 1;
    foreach (modes[i]) begin
      msg('{CMD_MGMT, 4, 8'h50, 8'h4d, 8'h53, modes[i]}, 0);
      repeat (4) @(posedge aclk);
      if (modes[i] inside {[1:3]}) exp_mode = modes[i];
      chk("outlet_mode", exp_mode, outlet_mode);
      axi_rd(REG_STAT);
      chk("stat_mode", exp_mode, rd[1:0]);
    end
    exp_fan = 0;
    repeat (2) begin
      msg('{CMD_FAN_CTL}, 0);
      repeat (4) @(posedge aclk);
      exp_fan ^= 1;
      chk("fan_on", exp_fan, fan_on);
      msg('{CMD_FAN_REQ}, 0);
      chk_rsp('{CMD_FAN_RSP, 3, exp_fan, 255, 255}, 5);
    end
    tv = '{8'h80, 8'h7f, 8'($urandom)};
    foreach (tv[i]) begin
      th = $urandom;
      ivl = 8'($urandom);
      axi_wr(REG_THERM, th);
      axi_wr(REG_CFG, {24'h00_0000, ivl});
      temp_in <= tv[i];
      msg('{CMD_TEMP_REQ}, 0);
      chk_rsp('{CMD_TEMP_RSP, 6, th[7:0], th[15:8], th[23:16], th[31:24],
                ivl, tv[i]}, 8);
    end
    for (int p = 0; p < 4; p++) begin
      msg('{CMD_MGMT, 5, 8'h53, 8'h45, 8'h43, p & 1, p >> 1}, 0);
      repeat (4) @(posedge aclk);
      chk("dn_ports", p, {port_dn2_en, port_dn1_en});
      msg('{CMD_MGMT, 3, 8'h45, 8'h43, 8'h52}, 0);
      chk_rsp('{CMD_MGMT, 5, 8'h52, 8'h45, 8'h43, p & 1, p >> 1},
              7);
    end
    axi_wr(REG_INFO, 32'h0000_0041);
    axi_rd(REG_INFO);
    chk("info_rd", RESP_SLVERR, rs);
    ld('{SUB_START}, 2, 0);
    ld('{SUB_REQ}, 1, 1);
    ld('{SUB_REQ}, 0, 0);
    ld('{SUB_START}, 0, 0);
    foreach (b[i]) b[i] = 8'($urandom);
    ld('{SUB_CHUNK, b[0], b[1], b[2]}, 0, 0);
    repeat (20) @(posedge aclk);
    foreach (b[i]) chk("img", b[i], node_u.img_q[i]);
    ld('{SUB_CHUNK, 8'h01}, 2, 0);
    ld('{SUB_DONE}, 0, 0);
    msg('{CMD_LOAD, 0, 1, SUB_STATQ}, 0);
    chk_rsp('{CMD_LOAD, 0, 8'h51, SUB_STAT, 8'h41}, 84);
    axi_wr(REG_STAT, 32'h0000_0000);
    chk("stat_wr", RESP_SLVERR, rs);
    axi_rd(REG_STAT);
    chk("stat", {2'h3, 2'h3, 1'b0, 2'(exp_mode)}, rd[6:0]);
    print_verdict;
  end
endmodule
